/* src/ibe_engine.sv */
// ibe_engine: byte engine of an i2c master with avalon-mm registers
// assumes open-drain pads outside (oe high pulls the line low) and
// slaves on the bus that acknowledge per the i2c protocol
//
// Operation
// - buffer write sets full flag, starts shifting
// - bit after scl falls, low then high period
// - eighth falling edge clears full, frees sda
// - ninth clock samples sda into ack status
// - after ninth clock: event, halt, scl low
// - address is seven bits plus direction bit
// - write during transmit sets collision, no store
// - receive request honoured only while idle
// - receive toggles scl per rollover, shifts sda
// - eighth receive edge: store, flag, go idle
// - reading buffer in receive clears full flag
// - received byte completing while full sets overflow
// - write during receive sets collision, discarded
// - ack sequence pulls scl, drives ack value
// - ack: period low, period high, then idle
// - write during ack sequence sets collision
// - stop: sda low, count, free scl, free sda
// - stop seen, period later clear and event
// - baud counter reloads from BAUD_W reload bits
// - counter waits while released scl reads low
module ibe_engine
   import ibe_pkg::*;
#(
   parameter int BAUD_W = 8 // width of the baud reload count
)
(
   input wire logic clk_sys, // system clock, 50 mhz
   input wire logic rstn, // synchronous reset, active low
   input wire logic [3:0] address, // avalon byte address
   input wire logic read, // avalon read request
   input wire logic write, // avalon write request
   input wire logic [3:0] byteenable, // avalon byte enables
   input wire logic [31:0] writedata, // avalon write data
   output logic [31:0] readdata, // avalon read data
   output logic waitrequest, // avalon wait, low for one answer cycle
   input wire logic scl_in, // scl line level
   output logic scl_out, // scl output value, always low
   output logic scl_oe, // high pulls scl low
   input wire logic sda_in, // sda line level
   output logic sda_out, // sda output value, always low
   output logic sda_oe // high pulls sda low
);

   if (BAUD_W < 1 || BAUD_W > 8)
   begin : g_chk
      $error("BAUD_W must lie between 1 and 8");
   end

   typedef struct packed {
      ibe_state_t st;
      logic [BAUD_W-1:0] cnt;
      logic [BAUD_W-1:0] baud;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic [7:0] buf_q;
      logic bf;
      logic write_collision_flag;
      logic ov;
      logic evt;
      logic stop_seen;
      logic ack_stat;
      logic rcv_req;
      logic ack_req;
      logic ack_val;
      logic stop_req;
      logic rx_mode;
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic scl_oe;
      logic sda_oe;
      logic wait_q;
      logic [31:0] rdata;
   } ibe_regs_t;

   ibe_regs_t s_r;
   ibe_regs_t s_nxt;

   // avalon answer helpers: a request is answered when wait_q is low
   logic acc;
   logic wr_go;
   logic rd_go;
   logic busy;
   logic scl_hi;
   logic sda_hi;
   logic tmo;

   assign acc = (read | write) & ~s_r.wait_q;
   assign wr_go = write & ~s_r.wait_q & byteenable[0];
   assign rd_go = read & ~s_r.wait_q;
   assign busy = (s_r.st != IBE_IDLE);
   assign scl_hi = s_r.scl_sy[1]; // second stage only
   assign sda_hi = s_r.sda_sy[1];
   assign tmo = (s_r.cnt == '0);

   // read mux, used to load read data one edge before the answer
   function automatic logic [31:0] rd_mux(input ibe_regs_t s,
                                          input logic [3:0] a);
      logic [31:0] v;
      v = IBE_UNMAPPED_RD;
      case (a)
         IBE_OFS_XFER: v[7:0] = s.buf_q;
         IBE_OFS_CTRL:
         begin
            v[IBE_C_RCV] = s.rcv_req;
            v[IBE_C_ACKSEQ] = s.ack_req;
            v[IBE_C_ACKVAL] = s.ack_val;
            v[IBE_C_STOP] = s.stop_req;
            v[IBE_C_ACK_STATUS_BIT] = s.ack_stat;
         end
         IBE_OFS_STAT:
         begin
            v[IBE_S_BF] = s.bf;
            v[IBE_S_WRITE_COLLISION_FLAG] = s.write_collision_flag;
            v[IBE_S_OV] = s.ov;
            v[IBE_S_EVT] = s.evt;
            v[IBE_S_STOPSEEN] = s.stop_seen;
         end
         IBE_OFS_BAUD: v[BAUD_W-1:0] = s.baud;
         default: v = IBE_UNMAPPED_RD;
      endcase
      return v;
   endfunction

   // next-state logic: bus side first, engine after so hardware sets win
   always_comb
   begin
      s_nxt = s_r;
      // pin synchronisers
      s_nxt.scl_sy = {s_r.scl_sy[0], scl_in};
      s_nxt.sda_sy = {s_r.sda_sy[0], sda_in};

      // bus handshake: one wait cycle, then one answer cycle
      if (acc)
         s_nxt.wait_q = 1'b1;
      else if (read | write)
      begin
         s_nxt.wait_q = 1'b0;
         s_nxt.rdata = rd_mux(s_r, address);
      end

      // read side effect on the buffer
      if (rd_go && address == IBE_OFS_XFER && s_r.rx_mode)
         s_nxt.bf = 1'b0;

      // register writes
      if (wr_go)
      begin
         case (address)
            IBE_OFS_XFER:
            begin
               if (busy)
                  s_nxt.write_collision_flag = 1'b1;
               else
               begin
                  // load shifter, first bit follows in the low phase
                  s_nxt.buf_q = writedata[7:0];
                  s_nxt.shreg = writedata[7:0];
                  s_nxt.bf = 1'b1;
                  s_nxt.rx_mode = 1'b0;
                  s_nxt.bitn = '0;
                  s_nxt.cnt = s_r.baud;
                  s_nxt.scl_oe = 1'b1;
                  s_nxt.st = IBE_TX_LOW;
               end
            end
            IBE_OFS_CTRL:
            begin
               s_nxt.ack_val = writedata[IBE_C_ACKVAL];
               if (!busy)
               begin
                  if (writedata[IBE_C_STOP])
                  begin
                     // pull sda low with scl held low
                     s_nxt.stop_req = 1'b1;
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st = IBE_SP_SDA;
                  end
                  else if (writedata[IBE_C_ACKSEQ])
                  begin
                     // scl low, ack value onto sda
                     s_nxt.ack_req = 1'b1;
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.sda_oe = ~writedata[IBE_C_ACKVAL];
                     s_nxt.cnt = s_r.baud;
                     s_nxt.st = IBE_AK_LOW;
                  end
                  else if (writedata[IBE_C_RCV])
                  begin
                     // reception only from idle, else dropped
                     s_nxt.rcv_req = 1'b1;
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.bitn = '0;
                     s_nxt.cnt = s_r.baud;
                     s_nxt.st = IBE_RX_LOW;
                  end
               end
            end
            IBE_OFS_STAT:
            begin
               // write one to clear; software clears collision
               if (writedata[IBE_S_WRITE_COLLISION_FLAG])
                  s_nxt.write_collision_flag = 1'b0;
               if (writedata[IBE_S_OV])
                  s_nxt.ov = 1'b0;
               if (writedata[IBE_S_EVT])
                  s_nxt.evt = 1'b0;
               if (writedata[IBE_S_STOPSEEN])
                  s_nxt.stop_seen = 1'b0;
            end
            IBE_OFS_BAUD: s_nxt.baud = writedata[BAUD_W-1:0];
            default: s_nxt.baud = s_r.baud;
         endcase
      end

      // engine
      case (s_r.st)
         IBE_IDLE: ; // keeps the count a bus request just loaded
         // scl held low one period with the bit on sda
         IBE_TX_LOW, IBE_RX_LOW, IBE_TA_LOW, IBE_AK_LOW:
         begin
            // sda moves a cycle after scl falls, never together with it
            if (s_r.st == IBE_TX_LOW)
               s_nxt.sda_oe = ~s_r.shreg[7]; // msb first
            else if (s_r.st == IBE_TA_LOW)
               s_nxt.sda_oe = 1'b0; // free sda for the ack
            // scl is released only once sda has settled
            if (tmo && s_nxt.sda_oe == s_r.sda_oe)
            begin
               s_nxt.scl_oe = 1'b0; // release scl
               s_nxt.cnt = s_r.baud;
               case (s_r.st)
                  IBE_TX_LOW: s_nxt.st = IBE_TX_HIGH;
                  IBE_RX_LOW: s_nxt.st = IBE_RX_HIGH;
                  IBE_TA_LOW: s_nxt.st = IBE_TA_HIGH;
                  default: s_nxt.st = IBE_AK_HIGH;
               endcase
            end
            else if (!tmo)
               s_nxt.cnt = s_r.cnt - 1'b1;
         end
         // high phases: counter reloaded until scl reads high
         IBE_TX_HIGH, IBE_RX_HIGH, IBE_TA_HIGH, IBE_AK_HIGH:
         begin
            if (!scl_hi)
               s_nxt.cnt = s_r.baud; // stretched by a slave
            else if (!tmo)
               s_nxt.cnt = s_r.cnt - 1'b1;
            else
            begin
               s_nxt.scl_oe = 1'b1; // falling edge of scl
               s_nxt.cnt = s_r.baud;
               case (s_r.st)
                  IBE_TX_HIGH:
                  begin
                     if (s_r.bitn == 3'h7)
                     begin
                        s_nxt.bf = 1'b0;
                        s_nxt.st = IBE_TA_LOW;
                     end
                     else
                     begin
                        // next of the eight byte bits, msb first
                        s_nxt.bitn = s_r.bitn + 1'b1;
                        s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                        s_nxt.st = IBE_TX_LOW;
                     end
                  end
                  IBE_TA_HIGH:
                  begin
                     s_nxt.ack_stat = sda_hi;
                     s_nxt.evt = 1'b1;
                     s_nxt.st = IBE_IDLE; // scl low, sda free
                  end
                  IBE_RX_HIGH:
                  begin
                     s_nxt.shreg = {s_r.shreg[6:0], sda_hi};
                     if (s_r.bitn == 3'h7)
                     begin
                        s_nxt.rcv_req = 1'b0;
                        s_nxt.buf_q = {s_r.shreg[6:0], sda_hi};
                        if (s_r.bf)
                           s_nxt.ov = 1'b1;
                        s_nxt.bf = 1'b1;
                        s_nxt.rx_mode = 1'b1;
                        s_nxt.evt = 1'b1;
                        s_nxt.st = IBE_IDLE;
                     end
                     else
                     begin
                        s_nxt.bitn = s_r.bitn + 1'b1;
                        s_nxt.st = IBE_RX_LOW;
                     end
                  end
                  default:
                  begin
                     s_nxt.ack_req = 1'b0;
                     s_nxt.st = IBE_IDLE;
                  end
               endcase
            end
         end
         // stop: wait for sda low, then one period with scl low
         IBE_SP_SDA:
         begin
            s_nxt.cnt = s_r.baud;
            if (!sda_hi)
               s_nxt.st = IBE_SP_LOW;
         end
         IBE_SP_LOW:
         begin
            if (tmo)
            begin
               s_nxt.scl_oe = 1'b0;
               s_nxt.cnt = s_r.baud;
               s_nxt.st = IBE_SP_HIGH;
            end
            else
               s_nxt.cnt = s_r.cnt - 1'b1;
         end
         IBE_SP_HIGH:
         begin
            if (!scl_hi)
               s_nxt.cnt = s_r.baud;
            else if (!tmo)
               s_nxt.cnt = s_r.cnt - 1'b1;
            else
            begin
               s_nxt.sda_oe = 1'b0;
               s_nxt.st = IBE_SP_SEEN;
            end
         end
         IBE_SP_SEEN:
         begin
            s_nxt.cnt = s_r.baud;
            if (sda_hi && scl_hi)
            begin
               s_nxt.stop_seen = 1'b1;
               s_nxt.st = IBE_SP_DONE;
            end
         end
         IBE_SP_DONE:
         begin
            if (tmo)
            begin
               s_nxt.stop_req = 1'b0;
               s_nxt.evt = 1'b1;
               s_nxt.st = IBE_IDLE;
            end
            else
               s_nxt.cnt = s_r.cnt - 1'b1;
         end
         default: s_nxt.st = IBE_IDLE;
      endcase

      // synchronous reset
      if (!rstn)
      begin
         s_nxt = '0;
         s_nxt.st = IBE_IDLE;
         s_nxt.baud = IBE_BAUD_RST[BAUD_W-1:0];
         s_nxt.cnt = IBE_BAUD_RST[BAUD_W-1:0];
         s_nxt.scl_sy = 2'h3;
         s_nxt.sda_sy = 2'h3;
         s_nxt.wait_q = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      s_r <= s_nxt;
   end

   // outputs straight from the state register, lines only pulled low
   assign readdata = s_r.rdata;
   assign waitrequest = s_r.wait_q;
   assign scl_oe = s_r.scl_oe;
   assign sda_oe = s_r.sda_oe;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

endmodule

/* src/ibe_pkg.sv */
// ibe_pkg: constants shared by the i2c master byte engine
// assumes a 32-bit avalon-mm register bus with byte addresses
package ibe_pkg;
   // register byte offsets
   localparam logic [3:0] IBE_OFS_XFER = 4'h0; // xfer_buffer
   localparam logic [3:0] IBE_OFS_CTRL = 4'h4; // control_register_two
   localparam logic [3:0] IBE_OFS_STAT = 4'h8; // port_status_register
   localparam logic [3:0] IBE_OFS_BAUD = 4'hc; // baud_reload_register
   // control_register_two fields
   localparam int IBE_C_RCV = 0; // receive_request_bit
   localparam int IBE_C_ACKSEQ = 1; // ack_sequence_request
   localparam int IBE_C_ACKVAL = 2; // ack_value_bit
   localparam int IBE_C_STOP = 3; // stop_request_bit
   localparam int IBE_C_ACK_STATUS_BIT = 4; // ack_status_bit, read only
   // port_status_register fields
   localparam int IBE_S_BF = 0; // buffer_full_flag, read only
   localparam int IBE_S_WRITE_COLLISION_FLAG = 1; // write_collision_flag, write 1 clears
   localparam int IBE_S_OV = 2; // receive_overflow_flag, write 1 clears
   localparam int IBE_S_EVT = 3; // port_event_flag, write 1 clears
   localparam int IBE_S_STOPSEEN = 4; // stop seen, write 1 clears
   // reset values
   localparam logic [7:0] IBE_BAUD_RST = 8'h09;
   localparam logic [31:0] IBE_UNMAPPED_RD = 32'h0000_0000;
   // engine states
   typedef enum logic [3:0] {
      IBE_IDLE, IBE_TX_LOW, IBE_TX_HIGH, IBE_TA_LOW, IBE_TA_HIGH,
      IBE_RX_LOW, IBE_RX_HIGH, IBE_AK_LOW, IBE_AK_HIGH,
      IBE_SP_SDA, IBE_SP_LOW, IBE_SP_HIGH, IBE_SP_SEEN, IBE_SP_DONE
   } ibe_state_t;
endpackage

/* tb/ibe_asserts.sv */
// ibe_asserts: port-level checks for the i2c byte engine
// assumes a bind to ibe_engine and a baud reload of 3 or more
module ibe_asserts (
   input wire logic clk_sys, // system clock
   input wire logic rstn, // sync reset, active low
   input wire logic read, // bus read
   input wire logic write, // bus write
   input wire logic waitrequest, // bus wait
   input wire logic scl_in, // scl level
   input wire logic scl_out, // scl value
   input wire logic scl_oe, // scl pull
   input wire logic sda_out, // sda value
   input wire logic sda_oe // sda pull
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // bus handshake and reset state
   chk_wait_answer:
      assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   chk_wait_one: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   chk_reset_idle:
      assert property ($rose(rstn) |-> !scl_oe && !sda_oe && waitrequest)
      else $error("lines or bus not idle after reset");
   // line values and timing
   chk_od_low: assert property (!scl_out && !sda_out)
      else $error("line output value not low");
   chk_scl_low: assert property ($rose(scl_oe) |-> scl_oe [*4])
      else $error("scl low phase too short");
   chk_scl_high: assert property ($fell(scl_oe) |-> !scl_oe [*4])
      else $error("scl high phase too short");
   chk_stretch_hold:
      assert property ((!scl_oe && !scl_in) [*3] |=> !scl_oe)
      else $error("scl pulled while still held low");
   chk_sda_setup:
      assert property ($rose(sda_oe) |-> scl_oe && $past(scl_oe))
      else $error("sda pulled before scl was low");
   // main scenarios
   cover property (write && !waitrequest);
   cover property ((!scl_oe && !scl_in) [*3]);
   cover property ($rose(sda_oe));
endmodule

bind ibe_engine ibe_asserts i_chk (.clk_sys, .rstn, .read, .write,
   .waitrequest, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe);

/* tb/ibe_i2c_slave.sv */
// ibe_i2c_slave: behavioural i2c slave on the resolved lines
// assumes the bench resolves both open-drain lines with pull-ups
module ibe_i2c_slave (
   input wire logic scl, // resolved scl level
   input wire logic sda, // resolved sda level
   input wire logic ack_on, // acknowledge address and data
   input wire logic stretch_on, // hold scl low after each fall
   input wire logic [7:0] rd_byte, // byte sent in read mode
   output logic scl_pull, // high holds scl low
   output logic sda_pull, // high holds sda low
   output logic [7:0] got // last byte seen
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   logic first = 1'b1;
   logic rdm = 1'b0;
   // released at start
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      got = 8'h00;
   end
   // a stop restarts address framing
   always @(posedge sda)
      if (scl === 1'b1)
      begin
         n = 0;
         first = 1'b1;
         rdm = 1'b0;
      end
   // sample on rising scl; a not-acknowledge ends read mode
   always @(posedge scl)
   begin
      if (n < 8)
         got = {got[6:0], sda};
      if (n == 7 && first)
         rdm = sda;
      if (n == 8 && !first && rdm && sda)
         rdm = 1'b0;
      if (n == 8)
         first = 1'b0;
      n = (n == 8) ? 0 : n + 1;
   end
   // change sda just after scl falls
   always @(negedge scl)
      if (n == 8)
         sda_pull = (first || !rdm) ? ack_on : 1'b0;
      else
         sda_pull = rdm && !first && !rd_byte[7 - n];
   // clock stretching
   always @(negedge scl)
      if (stretch_on)
      begin
         scl_pull = 1'b1;
         #600;
         scl_pull = 1'b0;
      end
endmodule

/* tb/testbench.sv */
// testbench: register-level tests of the i2c byte engine
// assumes ibe_engine and ibe_i2c_slave with pull-ups on both lines
module testbench
   import ibe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata, q;
   logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
   logic scl = 1'b1;
   logic sda = 1'b1;
   logic ack_on = 1'b1;
   logic stretch_on = 1'b0;
   logic [7:0] rd_byte = 8'hc3;
   logic [7:0] got;
   int fails = 0, checks_done = 0, lo_cnt = 0, lo_len = 0;
   // 50 mhz clock
   initial forever #10 clk_sys = ~clk_sys;
   // open-drain lines with pull-ups
   always @* scl = !(scl_oe === 1'b1 || scl_pull === 1'b1);
   always @* sda = !(sda_oe === 1'b1 || sda_pull === 1'b1);
   // length of the last scl low phase driven by the engine
   always @(posedge clk_sys)
      if (scl_oe === 1'b1)
         lo_cnt <= lo_cnt + 1;
      else
      begin
         if (lo_cnt != 0)
            lo_len <= lo_cnt;
         lo_cnt <= 0;
      end
   ibe_engine i_dut (.clk_sys, .rstn, .address, .read, .write,
      .byteenable, .writedata, .readdata, .waitrequest,
      .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
   ibe_i2c_slave i_slave (.scl, .sda, .ack_on, .stretch_on, .rd_byte,
      .scl_pull, .sda_pull, .got);
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer; read data lands in q
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do
         @(posedge clk_sys);
      while (waitrequest !== 1'b0 && ++n < 20);
      if (waitrequest !== 1'b0)
         fails++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // poll a register until the masked bits match
   task automatic poll(input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] v);
      int n;
      n = 0;
      do
         bus(1'b0, a, 32'h0);
      while ((q & m) !== v && ++n < 400);
      chk(q & m, v);
   endtask
   task automatic wait_evt;
      poll(IBE_OFS_STAT, 32'h8, 32'h8);
      bus(1'b1, IBE_OFS_STAT, 32'h8);
   endtask
   task automatic tx(input logic [7:0] b);
      bus(1'b1, IBE_OFS_XFER, {24'h0, b});
      wait_evt();
      chk(32'(got), 32'(b));
   endtask
   // acknowledge sequence, optionally probing refusals meanwhile
   task automatic ack(input logic v, input logic p);
      bus(1'b1, IBE_OFS_CTRL, {29'h0, v, 2'b10});
      if (p)
      begin
         bus(1'b1, IBE_OFS_XFER, 32'h22);
         bus(1'b1, IBE_OFS_CTRL, {29'h0, v, 2'b01});
      end
      poll(IBE_OFS_CTRL, 32'h2, 32'h0);
      chk(32'(sda_oe), 32'(!v));
      if (p)
         rd(IBE_OFS_CTRL, 32'h0);
      bus(1'b0, IBE_OFS_STAT, 32'h0);
      chk(q & 32'h2, {30'h0, p, 1'b0});
      bus(1'b1, IBE_OFS_STAT, 32'h1e);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #400us;
      fails++;
      test_done();
   end
   // test sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(IBE_OFS_BAUD, 32'h9);
      rd(IBE_OFS_CTRL, 32'h0);
      rd(IBE_OFS_STAT, 32'h0);
      bus(1'b1, 4'h6, 32'hff);
      rd(4'h6, IBE_UNMAPPED_RD);
      bus(1'b1, IBE_OFS_BAUD, 32'h103);
      rd(IBE_OFS_BAUD, 32'h3);
      // a write without its low byte lane is answered but ignored
      byteenable <= 4'he;
      bus(1'b1, IBE_OFS_BAUD, 32'h7);
      byteenable <= 4'hf;
      rd(IBE_OFS_BAUD, 32'h3);
      // address byte, write direction, collision while shifting
      bus(1'b1, IBE_OFS_XFER, 32'ha4);
      rd(IBE_OFS_STAT, 32'h1);
      bus(1'b1, IBE_OFS_XFER, 32'h77);
      rd(IBE_OFS_STAT, 32'h3);
      chk(lo_len, 32'h4);
      wait_evt();
      chk(32'(got), 32'ha4);
      rd(IBE_OFS_STAT, 32'h2);
      rd(IBE_OFS_CTRL, 32'h0);
      chk(lo_len, 32'h4);
      chk(32'({scl, sda}), 32'h1);
      bus(1'b1, IBE_OFS_STAT, 32'h1e);
      rd(IBE_OFS_STAT, 32'h0);
      // data byte, stretched clock, not acknowledged
      ack_on <= 1'b0;
      stretch_on <= 1'b1;
      tx(8'h5a);
      rd(IBE_OFS_CTRL, 32'h10);
      stretch_on <= 1'b0;
      ack_on <= 1'b1;
      bus(1'b1, IBE_OFS_CTRL, 32'h8);
      wait_evt();
      rd(IBE_OFS_STAT, 32'h10);
      rd(IBE_OFS_CTRL, 32'h10);
      chk(32'({scl, sda}), 32'h3);
      bus(1'b1, IBE_OFS_STAT, 32'h10);
      // read transfer
      tx(8'ha5);
      bus(1'b1, IBE_OFS_CTRL, 32'h1);
      bus(1'b1, IBE_OFS_XFER, 32'h11);
      wait_evt();
      rd(IBE_OFS_STAT, 32'h3);
      rd(IBE_OFS_CTRL, 32'h0);
      rd(IBE_OFS_XFER, 32'hc3);
      rd(IBE_OFS_STAT, 32'h2);
      bus(1'b1, IBE_OFS_STAT, 32'h1e);
      ack(1'b0, 1'b1);
      bus(1'b1, IBE_OFS_CTRL, 32'h1);
      wait_evt();
      ack(1'b0, 1'b0);
      bus(1'b1, IBE_OFS_CTRL, 32'h1);
      wait_evt();
      rd(IBE_OFS_STAT, 32'h5);
      ack(1'b1, 1'b0);
      bus(1'b1, IBE_OFS_CTRL, 32'h8);
      wait_evt();
      test_done();
   end
endmodule
